// [rtl/rhp_regs.sv]
`timescale 1ns/1ps
module rhp_regs #(
    parameter int N_PORTS = rhp_pkg::NUM_PORTS
) (
    input  wire logic                      i_clk,
    input  wire logic                      i_arst_n,
    input  wire logic                      i_ce,
    input  wire rhp_pkg::rhp_req_s         i_req,
    output logic [rhp_pkg::DATA_W-1:0]     o_rdata,
    input  wire logic                      i_power_switching_select,
    input  wire logic                      i_overcurrent_indicator,
    input  wire logic [N_PORTS-1:0]        i_strap_per_port_power_mask,
    input  wire logic [N_PORTS-1:0]        i_strap_removable_flags,
    input  wire logic [N_PORTS-1:0]        i_port_power_on,
    input  wire logic [N_PORTS-1:0]        i_port_power_off,
    output logic [N_PORTS-1:0]             o_port_power,
    output logic [N_PORTS-1:0]             o_per_port_power_mask,
    output logic [N_PORTS-1:0]             o_removable_flags,
    output logic                           o_remote_wakeup_enable,
    output logic                           o_irq
);
    import rhp_pkg::*;

    rhp_regs_s          q;
    rhp_regs_s          d;
    logic               wr_desc_b;
    logic               wr_hub_st;
    logic               global_on;
    logic               global_off;
    logic               oc_change;
    logic [N_PORTS-1:0] masked;

    // ******************************
    // Command decode
    // ******************************
    // descriptor B codes
    assign wr_desc_b  = i_req.wr && (i_req.cmd == CMD_WR_DESC_B);
    assign wr_hub_st  = i_req.wr && (i_req.cmd == CMD_WR_HUB_ST);
    assign global_on  = wr_hub_st && i_req.wdata[HS_PWR_ON];
    assign global_off = wr_hub_st && i_req.wdata[HS_PWR_OFF];
    assign oc_change  = q.strap_done && (i_overcurrent_indicator != q.oc_ind);
    assign masked     = {N_PORTS{i_power_switching_select}} & q.pwr_mask;

    // ******************************
    // Next state
    // ******************************
    always_comb begin
        d       = q;
        d.rdata = '0;
        // straps caught once after release, not under reset
        if (!q.strap_done) begin
            d.strap_done = 1'b1;
            d.pwr_mask   = i_strap_per_port_power_mask;
            d.removable  = i_strap_removable_flags;
        end
        d.oc_ind = i_overcurrent_indicator;
        // bit 0 reserved, removable flags sit at bits 2..1, power mask at bits 18..17
        if (wr_desc_b) begin
            d.pwr_mask  = i_req.wdata[DB_PWR_MASK_LSB +: N_PORTS];
            d.removable = i_req.wdata[DB_REMOVABLE_LSB +: N_PORTS];
        end
        if (wr_hub_st) begin
            if (i_req.wdata[HS_WAKE_EN]) begin
                d.wake_en = 1'b1;
            end
            if (i_req.wdata[HS_WAKE_CLR]) begin
                d.wake_en = 1'b0;
            end
            if (i_req.wdata[HS_OC_CHG]) begin
                d.oc_chg = 1'b0;
            end
        end
        if (oc_change) begin
            d.oc_chg = 1'b1;
        end
        if (i_req.wr && (i_req.cmd == CMD_WR_IRQ_MASK)) begin
            d.irq_mask = i_req.wdata[IRQ_W-1:0];
        end
        // Read clears; events in the same cycle survive
        if (i_req.rd && (i_req.cmd == CMD_RD_IRQ_ST)) begin
            d.irq_stat = '0;
        end
        if (oc_change) begin
            d.irq_stat[IRQ_OC_CHG] = 1'b1;
        end
        if (global_on || global_off) begin
            d.irq_stat[IRQ_PWR_CMD] = 1'b1;
        end
        // ******************************
        // Read data
        // ******************************
        if (i_req.rd) begin
            case (i_req.cmd)
                CMD_RD_DESC_B: begin
                    d.rdata[DB_PWR_MASK_LSB +: N_PORTS]  = q.pwr_mask;
                    d.rdata[DB_REMOVABLE_LSB +: N_PORTS] = q.removable;
                end
                CMD_RD_HUB_ST: begin
                    d.rdata[HS_OC_CHG]  = q.oc_chg;
                    d.rdata[HS_WAKE_EN] = q.wake_en;
                    d.rdata[HS_OC_IND]  = q.oc_ind;
                end
                CMD_RD_IRQ_ST: begin
                    d.rdata[IRQ_W-1:0] = q.irq_stat;
                end
                CMD_RD_IRQ_MASK: begin
                    d.rdata[IRQ_W-1:0] = q.irq_mask;
                end
                default: begin
                    d.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            q.strap_done <= 1'b0;
            q.pwr_mask   <= '0;
            q.removable  <= '0;
            q.wake_en    <= RST_WAKE_EN;
            q.oc_ind     <= RST_OC_IND;
            q.oc_chg     <= RST_OC_CHG;
            q.irq_stat   <= RST_IRQ;
            q.irq_mask   <= RST_IRQ;
            q.rdata      <= '0;
        end else if (i_ce) begin
            q <= d;
        end
    end

    // ******************************
    // Port power switches
    // ******************************
    for (genvar p = 0; p < N_PORTS; p++) begin : g_port
        rhp_port_pwr u_pwr (
            .i_clk        (i_clk),
            .i_arst_n     (i_arst_n),
            .i_ce         (i_ce),
            .i_masked     (masked[p]),
            .i_global_on  (global_on),
            .i_global_off (global_off),
            .i_port_on    (i_port_power_on[p]),
            .i_port_off   (i_port_power_off[p]),
            .o_power      (o_port_power[p])
        );
    end

    assign o_rdata                = q.rdata;
    assign o_per_port_power_mask  = q.pwr_mask;
    assign o_removable_flags      = q.removable;
    assign o_remote_wakeup_enable = q.wake_en;
    assign o_irq                  = |(q.irq_stat & q.irq_mask);

    // ******************************
    // Checks
    // ******************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    property p_desc_read;
        i_ce && i_req.rd && i_req.cmd == CMD_RD_DESC_B |=>
            o_rdata == {13'h0, $past(q.pwr_mask), 14'h0, $past(q.removable), 1'b0};
    endproperty
    a_desc_read: assert property (p_desc_read) else $error("descriptor read bad");

    property p_desc_write;
        i_ce && q.strap_done && wr_desc_b |=>
            o_per_port_power_mask == $past(i_req.wdata[18:17]) &&
            o_removable_flags == $past(i_req.wdata[2:1]);
    endproperty
    a_desc_write: assert property (p_desc_write) else $error("descriptor write lost");

    property p_masked_hold;
        i_ce && i_power_switching_select && q.pwr_mask[0] && wr_hub_st &&
            !i_port_power_on[0] && !i_port_power_off[0] |=> $stable(o_port_power[0]);
    endproperty
    a_masked_hold: assert property (p_masked_hold) else $error("masked port moved");

    property p_global_mode;
        i_ce && !i_power_switching_select && global_on && !global_off |=>
            o_port_power == {N_PORTS{1'b1}};
    endproperty
    a_global_mode: assert property (p_global_mode) else $error("global on missed");

    property p_status_read;
        i_ce && i_req.rd && i_req.cmd == CMD_RD_HUB_ST |=>
            o_rdata[HS_PWR_ON] == 1'b0 && o_rdata[HS_PWR_OFF] == 1'b0 &&
            o_rdata[HS_WAKE_CLR] == 1'b0 && o_rdata[HS_OC_CHG] == $past(q.oc_chg) &&
            o_rdata[HS_OC_IND] == $past(q.oc_ind);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read bad");

    property p_wakeup;
        i_ce && wr_hub_st && i_req.wdata[HS_WAKE_CLR] |=> !o_remote_wakeup_enable;
    endproperty
    a_wakeup: assert property (p_wakeup) else $error("wakeup not cleared");

    property p_wake_set;
        i_ce && wr_hub_st && i_req.wdata[HS_WAKE_EN] && !i_req.wdata[HS_WAKE_CLR] |=>
            o_remote_wakeup_enable;
    endproperty
    a_wake_set: assert property (p_wake_set) else $error("wakeup not set");

    property p_oc_change;
        i_ce && oc_change |=> q.oc_chg && q.irq_stat[IRQ_OC_CHG];
    endproperty
    a_oc_change: assert property (p_oc_change) else $error("oc change lost");

    property p_power_off;
        i_ce && global_off && !masked[1] |=> !o_port_power[1];
    endproperty
    a_power_off: assert property (p_power_off) else $error("power off missed");

    property p_power_on;
        i_ce && global_on && !global_off && !masked[1] |=> o_port_power[1];
    endproperty
    a_power_on: assert property (p_power_on) else $error("power on missed");

    property p_oc_clear;
        i_ce && wr_hub_st && i_req.wdata[HS_OC_CHG] && !oc_change |=> !q.oc_chg;
    endproperty
    a_oc_clear: assert property (p_oc_clear) else $error("oc flag not cleared");

    property p_rdata_idle;
        i_ce && !i_req.rd |=> o_rdata == '0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

    property p_port_on;
        i_ce && masked[0] && i_port_power_on[0] && !i_port_power_off[0] |=> o_port_power[0];
    endproperty
    a_port_on: assert property (p_port_on) else $error("port on missed");

    property p_port_off;
        i_ce && masked[0] && i_port_power_off[0] |=> !o_port_power[0];
    endproperty
    a_port_off: assert property (p_port_off) else $error("port off missed");

    property p_mask_ignored;
        i_ce && !i_power_switching_select && !global_on && !global_off |=>
            $stable(o_port_power);
    endproperty
    a_mask_ignored: assert property (p_mask_ignored) else $error("port moved in global mode");

    // Reset sampled high keeps the attempt off the release edge itself
    property p_strap_load;
        i_arst_n && i_ce && !q.strap_done && !wr_desc_b |=>
            o_per_port_power_mask == $past(i_strap_per_port_power_mask) &&
            o_removable_flags == $past(i_strap_removable_flags);
    endproperty
    a_strap_load: assert property (p_strap_load) else $error("straps not loaded");

    property p_irq_clear;
        i_ce && i_req.rd && i_req.cmd == CMD_RD_IRQ_ST && !oc_change && !global_on &&
            !global_off |=> q.irq_stat == '0;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq status not cleared");

    // ******************************
    // Coverage
    // ******************************
    c_oc_irq: cover property (oc_change ##1 o_irq);
    c_per_port: cover property (i_power_switching_select && q.pwr_mask[0] && global_on);
    c_desc_wr: cover property (wr_desc_b ##1 o_removable_flags != '0);
    c_irq_drop: cover property (o_irq ##1 !o_irq);
    c_wake: cover property (o_remote_wakeup_enable ##[1:20] !o_remote_wakeup_enable);

endmodule

// [rtl/rhp_pkg.sv]
package rhp_pkg;

    // ******************************
    // Geometry
    // ******************************
    localparam int NUM_PORTS   = 2;
    localparam int CMD_W       = 8;
    localparam int DATA_W      = 32;
    localparam int IRQ_W       = 2;

    // ******************************
    // Command codes
    // ******************************
    localparam logic [CMD_W-1:0] CMD_RD_DESC_B   = 8'h13;
    localparam logic [CMD_W-1:0] CMD_WR_DESC_B   = 8'h93;
    localparam logic [CMD_W-1:0] CMD_RD_HUB_ST   = 8'h14;
    localparam logic [CMD_W-1:0] CMD_WR_HUB_ST   = 8'h94;
    localparam logic [CMD_W-1:0] CMD_RD_IRQ_ST   = 8'h30;
    localparam logic [CMD_W-1:0] CMD_RD_IRQ_MASK = 8'h31;
    localparam logic [CMD_W-1:0] CMD_WR_IRQ_MASK = 8'hb1;

    // ******************************
    // Field positions
    // ******************************
    localparam int DB_PWR_MASK_LSB  = 17;
    localparam int DB_REMOVABLE_LSB = 1;
    localparam int HS_WAKE_CLR      = 31;
    localparam int HS_OC_CHG        = 17;
    localparam int HS_PWR_ON        = 16;
    localparam int HS_WAKE_EN       = 15;
    localparam int HS_OC_IND        = 1;
    localparam int HS_PWR_OFF       = 0;
    localparam int IRQ_OC_CHG  = 0;
    localparam int IRQ_PWR_CMD = 1;

    // ******************************
    // Reset values
    // ******************************
    localparam logic             RST_WAKE_EN = 1'b0;
    localparam logic             RST_OC_IND  = 1'b0;
    localparam logic             RST_OC_CHG  = 1'b0;
    localparam logic             RST_POWER = 1'b0;
    localparam logic [IRQ_W-1:0] RST_IRQ   = 2'h0;

    // ******************************
    // Carriers
    // ******************************
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [CMD_W-1:0]  cmd;
        logic [DATA_W-1:0] wdata;
    } rhp_req_s;

    typedef struct packed {
        logic power;
    } rhp_port_s;

    typedef struct packed {
        logic                 strap_done;
        logic [NUM_PORTS-1:0] pwr_mask;
        logic [NUM_PORTS-1:0] removable;
        logic                 wake_en;
        logic                 oc_ind;
        logic                 oc_chg;
        logic [IRQ_W-1:0]     irq_stat;
        logic [IRQ_W-1:0]     irq_mask;
        logic [DATA_W-1:0]    rdata;
    } rhp_regs_s;

endpackage

// [rtl/rhp_port_pwr.sv]
`timescale 1ns/1ps
module rhp_port_pwr (
    input  wire logic i_clk,
    input  wire logic i_arst_n,
    input  wire logic i_ce,
    input  wire logic i_masked,
    input  wire logic i_global_on,
    input  wire logic i_global_off,
    input  wire logic i_port_on,
    input  wire logic i_port_off,
    output logic      o_power
);
    import rhp_pkg::*;

    rhp_port_s q;
    rhp_port_s d;

    // ******************************
    // Power state
    // ******************************
    always_comb begin
        d = q;
        if (i_masked) begin
            if (i_port_on) begin
                d.power = 1'b1;
            end
            if (i_port_off) begin
                d.power = 1'b0;
            end
        end else begin
            if (i_global_on) begin
                d.power = 1'b1;
            end
            if (i_global_off) begin
                d.power = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            q.power <= RST_POWER;
        end else if (i_ce) begin
            q <= d;
        end
    end

    assign o_power = q.power;

endmodule

// [testbench/tb.sv]
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb;
    import rhp_pkg::*;

    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    logic              clk;
    logic              arst_n;
    logic              ce;
    rhp_req_s          req;
    logic [DATA_W-1:0] rdata;
    logic              psel;
    logic              oc_in;
    logic [1:0]        pon;
    logic [1:0]        poff;
    logic [1:0]        pwr;
    logic [1:0]        mask;
    logic [1:0]        rem;
    logic              wake;
    logic              irq;
    logic [DATA_W-1:0] rd_v;
    int                mismatches;
    int                total_checks;

    rhp_regs rhp_regs_inst (
        .i_clk                       (clk),
        .i_arst_n                    (arst_n),
        .i_ce                        (ce),
        .i_req                       (req),
        .o_rdata                     (rdata),
        .i_power_switching_select    (psel),
        .i_overcurrent_indicator     (oc_in),
        .i_strap_per_port_power_mask (2'h2),
        .i_strap_removable_flags     (2'h1),
        .i_port_power_on             (pon),
        .i_port_power_off            (poff),
        .o_port_power                (pwr),
        .o_per_port_power_mask       (mask),
        .o_removable_flags           (rem),
        .o_remote_wakeup_enable      (wake),
        .o_irq                       (irq)
    );

    // ****************************************
    // Bus and pin tasks
    // ****************************************
    task automatic wr(input logic [7:0] c, input logic [31:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, cmd: c, wdata: d};
        @(posedge clk);
        req <= '0;
        #1;
    endtask

    // Read data stand only in the cycle after the read edge
    task automatic rd(input logic [7:0] c);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, cmd: c, wdata: 32'h0};
        @(posedge clk);
        req <= '0;
        #1 rd_v = rdata;
    endtask

    task automatic pp(input logic [1:0] on, input logic [1:0] off);
        @(posedge clk);
        pon  <= on;
        poff <= off;
        @(posedge clk);
        pon  <= 2'h0;
        poff <= 2'h0;
        #1;
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        rd(8'h13);
        `CHK(rd_v, 32'h0004_0002)
        rd(8'h14);
        `CHK(rd_v, 32'h0)
        @(posedge clk);
        #1 `CHK(rdata, 32'h0)
        `CHK({pwr, wake, irq}, 4'h0)
        rd(8'h55);
        `CHK(rd_v, 32'h0)
    endtask

    task automatic t_desc();
        wr(8'h93, 32'h0002_0004);
        `CHK({mask, rem}, 4'h6)
        rd(8'h13);
        `CHK(rd_v, 32'h0002_0004)
    endtask

    task automatic t_wake();
        @(posedge clk);
        ce <= 1'b0;
        wr(8'h94, 32'h0000_8000);
        @(posedge clk);
        ce <= 1'b1;
        `CHK(wake, 1'b0)
        wr(8'h94, 32'h0000_8000);
        rd(8'h14);
        `CHK(rd_v, 32'h0000_8000)
        wr(8'h94, 32'h0);
        `CHK(wake, 1'b1)
        wr(8'h94, 32'h8000_0000);
        `CHK(wake, 1'b0)
    endtask

    // Port 0 is masked; the mask counts only in per-port mode
    task automatic t_power();
        psel <= 1'b0;
        wr(8'h94, 32'h0001_0000);
        `CHK(pwr, 2'h3)
        rd(8'h14);
        `CHK(rd_v, 32'h0)
        pp(2'h3, 2'h0);
        `CHK(pwr, 2'h3)
        wr(8'h94, 32'h0000_0001);
        `CHK(pwr, 2'h0)
        psel <= 1'b1;
        wr(8'h94, 32'h0001_0000);
        `CHK(pwr, 2'h2)
        pp(2'h3, 2'h0);
        `CHK(pwr, 2'h3)
        wr(8'h94, 32'h0000_0001);
        `CHK(pwr, 2'h1)
        pp(2'h0, 2'h1);
        `CHK(pwr, 2'h0)
    endtask

    task automatic t_irq();
        rd(8'h30);
        wr(8'hb1, 32'h1);
        rd(8'h31);
        `CHK(rd_v, 32'h1)
        @(posedge clk);
        oc_in <= 1'b1;
        rd(8'h14);
        `CHK(rd_v, 32'h0002_0002)
        `CHK(irq, 1'b1)
        rd(8'h30);
        `CHK(rd_v, 32'h1)
        `CHK(irq, 1'b0)
        wr(8'h94, 32'h0);
        rd(8'h14);
        `CHK(rd_v, 32'h0002_0002)
        wr(8'h94, 32'h0002_0000);
        rd(8'h14);
        `CHK(rd_v, 32'h0000_0002)
        wr(8'h94, 32'h0000_0001);
        `CHK(irq, 1'b0)
        rd(8'h30);
        `CHK(rd_v, 32'h2)
        @(posedge clk);
        oc_in <= 1'b0;
        rd(8'h14);
        `CHK(rd_v, 32'h0002_0000)
    endtask

    // ****************************************
    // Clock, reset, sequence, watchdog
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        arst_n = 1'b0;
        ce     = 1'b1;
        req    = '0;
        psel   = 1'b0;
        oc_in  = 1'b0;
        pon    = 2'h0;
        poff   = 2'h0;
        rd_v   = 32'h0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset();
        t_desc();
        t_wake();
        t_power();
        t_irq();
        stop_test();
    end

    // A hang is cut short here and counted as a mismatch
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        stop_test();
    end
endmodule
